/* verilog/cfs_core.sv */
// instruction fetch/execute sequencer with single-cycle barrel shifter
`timescale 1ns/10ps
// Notes on behaviour
// - barrel shifts 1 to 15 places in one cycle
// - arithmetic right, logical right and left shifts
// - shift operand and result are working registers only
// - single-place shifts go through the alu path
// - fetch overlaps execute, one cycle per instruction
// - double-word move: two cycles, prefetch held
// - branch redirect discards prefetch, two cycles
// - skipped two-word instruction: three cycles, nops
// - return takes three cycles
// - table op suspends fetch, held instruction follows
// - two-word instruction: second fetch is operand
// - orphan second word executes as nop
// - data address dependency inserts one stall
// - return prefetch beyond memory raises trap
// - register written then used for ea delays
module cfs_core (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // program memory side
  output logic [cfs_pkg::PC_W-1:0]        prog_addr,
  output logic                            prog_rd,
  output logic                            prog_tbl,
  input  wire logic [cfs_pkg::WORD_W-1:0] pm_rdata,
  // execute side inputs
  input  wire logic                       skip_cond,
  input  wire logic [cfs_pkg::PC_W-1:0]   flow_target,
  input  wire logic [cfs_pkg::PC_W-1:0]   ret_addr,
  input  wire logic [cfs_pkg::PC_W-1:0]   tbl_addr,
  input  wire logic [cfs_pkg::DATA_W-1:0] shift_src,
  // execute side outputs
  output logic                            exec_valid,
  output logic [cfs_pkg::WORD_W-1:0]      exec_word,
  output logic                            exec_nop,
  output logic                            exec_opnd,
  output logic                            exec_rw2,
  output logic                            stall,
  output logic                            addr_trap,
  output logic                            wreg_we,
  output logic [cfs_pkg::REG_W-1:0]       wreg_wsel,
  output logic [cfs_pkg::DATA_W-1:0]      wreg_wdata,
  output logic                            alu_shift
);
  import cfs_pkg::*;

  function automatic cfs_class_type cls_of(input logic [WORD_W-1:0] w);
    return cfs_class_type'(w[CLS_HI:CLS_LO]);
  endfunction

  function automatic cfs_shop_type op_of(input logic [WORD_W-1:0] w);
    return cfs_shop_type'(w[SOP_HI:SOP_LO]);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // barrel shifter on the word now being decoded
  logic [WORD_W-1:0] cur;
  logic [AMT_W-1:0]  amt;
  cfs_shop_type      sop;
  logic [DATA_W-1:0] stg [0:AMT_W];
  logic [DATA_W-1:0] alu1;
  assign amt    = cur[AMT_HI:AMT_LO];
  assign sop    = op_of(cur);
  assign stg[0] = shift_src; // operand only from the register read port
  generate
    for (genvar g = 0; g < AMT_W; g++) begin : g_stage
      localparam int SH = 1 << g;
      // log stages keep the whole 15-place range inside one cycle
      assign stg[g+1] = !amt[g] ? stg[g] :
                        (sop == shift_left_op)     ? (stg[g] << SH) :
                        (sop == arith_shift_right) ? DATA_W'($signed(stg[g]) >>> SH) :
                        (stg[g] >> SH);
    end
  endgenerate
  // one-place shift in the alu, keeps the barrel off the common path
  always_comb begin
    case (sop)
      shift_left_op:     alu1 = {shift_src[DATA_W-2:0], 1'b0};
      arith_shift_right: alu1 = {shift_src[DATA_W-1], shift_src[DATA_W-1:1]};
      default:           alu1 = {1'b0, shift_src[DATA_W-1:1]};
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer state
  cfs_state_type     state_q, state_d;
  logic [PC_W-1:0]   pc_q, pc_d, prog_addr_q, prog_addr_d;
  logic [WORD_W-1:0] hold_q, hold_d, exec_word_q, exec_word_d;
  logic              hold_v_q, hold_v_d, fetched_q, fetched_d, discard_q, discard_d;
  logic              pend2_q, pend2_d, nullify_q, nullify_d, lwr_q, lwr_d;
  logic [REG_W-1:0]  ldst_q, ldst_d, wreg_wsel_q, wreg_wsel_d;
  logic [DATA_W-1:0] wreg_wdata_q, wreg_wdata_d;
  logic prog_rd_q, prog_rd_d, prog_tbl_q, prog_tbl_d, exec_valid_q, exec_valid_d;
  logic exec_nop_q, exec_nop_d, exec_opnd_q, exec_opnd_d, exec_rw2_q, exec_rw2_d;
  logic stall_q, stall_d, addr_trap_q, addr_trap_d, wreg_we_q, wreg_we_d;
  logic alu_shift_q, alu_shift_d;
  logic avail, dep, fetch;
  cfs_class_type cls;

  // next-state: one decision per instruction cycle
  always_comb begin
    cur   = hold_v_q ? hold_q : pm_rdata;
    avail = hold_v_q | (fetched_q & ~discard_q); // discarded prefetch never executes
    cls   = cls_of(cur);
    dep   = lwr_q & cur[SIND_BIT] & (cur[SRC_HI:SRC_LO] == ldst_q);
    fetch = 1'b0;
    state_d = state_q;  pc_d = pc_q;  prog_addr_d = prog_addr_q;
    hold_d = hold_q;  hold_v_d = hold_v_q;  discard_d = 1'b0;
    pend2_d = pend2_q;  nullify_d = nullify_q;  lwr_d = 1'b0;  ldst_d = ldst_q;
    prog_tbl_d = 1'b0;  exec_valid_d = 1'b0;  exec_word_d = exec_word_q;
    exec_nop_d = 1'b0;  exec_opnd_d = 1'b0;  exec_rw2_d = 1'b0;
    stall_d = 1'b0;  addr_trap_d = 1'b0;  wreg_we_d = 1'b0;  alu_shift_d = 1'b0;
    wreg_wsel_d = wreg_wsel_q;  wreg_wdata_d = wreg_wdata_q;
    case (state_q)
      ST_RUN: begin
        if (!avail) begin
          fetch = 1'b1;
        end else if (pend2_q) begin
          // operand word completes the two-word instruction
          exec_valid_d = 1'b1;
          exec_word_d  = cur;
          exec_opnd_d  = 1'b1;
          pend2_d      = 1'b0;
          hold_v_d     = 1'b0;
          fetch        = 1'b1;
        end else if (nullify_q || cls == CLS_TWO_HI) begin
          // skipped word, or second word seen without its first
          exec_valid_d = 1'b1;
          exec_word_d  = cur;
          exec_nop_d   = 1'b1;
          nullify_d    = 1'b0;
          hold_v_d     = 1'b0;
          fetch        = 1'b1;
        end else if (dep) begin
          // park the dependent word until the register write lands
          stall_d  = 1'b1;
          hold_d   = cur;
          hold_v_d = 1'b1;
        end else begin
          exec_valid_d = 1'b1;
          exec_word_d  = cur;
          hold_v_d     = 1'b0;
          fetch        = 1'b1;
          lwr_d        = cur[DWR_BIT];
          ldst_d       = cur[DST_HI:DST_LO];
          case (cls)
            CLS_SHIFT: begin
              wreg_we_d    = 1'b1;
              wreg_wsel_d  = cur[DST_HI:DST_LO];
              alu_shift_d  = (amt == AMT_ONE);
              wreg_wdata_d = (amt == AMT_ONE) ? alu1 : stg[AMT_W];
            end
            CLS_DWM:    state_d = ST_DWM2;
            CLS_BRANCH: discard_d = 1'b1;
            CLS_SKIP:   nullify_d = skip_cond;
            CLS_RET: begin
              discard_d = 1'b1;
              state_d   = ST_RET2;
            end
            CLS_TBL:    state_d = ST_TBL;
            CLS_TWO_LO: pend2_d = 1'b1;
            default: ;
          endcase
        end
      end
      ST_DWM2: begin
        // second read/write; the prefetched word waits, nothing is flushed
        exec_valid_d = 1'b1;
        exec_rw2_d   = 1'b1;
        lwr_d        = lwr_q;
        hold_d       = pm_rdata;
        hold_v_d     = fetched_q;
        state_d      = ST_RUN;
      end
      ST_TBL: begin
        // program memory cycle steals the fetch slot
        prog_tbl_d  = 1'b1;
        prog_addr_d = tbl_addr;
        hold_d      = pm_rdata;
        hold_v_d    = fetched_q;
        state_d     = ST_RUN;
      end
      ST_RET2: state_d = ST_RET3;
      ST_RET3: begin
        // the refill reaches one word past the return address
        addr_trap_d = (pc_q > PM_LIMIT) || (pc_q > PM_LIMIT - PC_STEP);
        fetch       = 1'b1;
        state_d     = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
    fetched_d = fetch;
    prog_rd_d = fetch | prog_tbl_d;
    if (fetch) begin
      prog_addr_d = pc_q;
      pc_d        = pc_q + PC_STEP;
    end
    // redirect overrides the sequential increment
    if (state_q == ST_RUN && avail && !pend2_q && !nullify_q && !dep) begin
      if (cls == CLS_BRANCH) pc_d = flow_target;
      if (cls == CLS_RET)    pc_d = ret_addr;
    end
  end

  // registers of the sequencer
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_RUN;  pc_q <= PC_RESET;  prog_addr_q <= PC_RESET;
      hold_q <= '0;  hold_v_q <= 1'b0;  fetched_q <= 1'b0;  discard_q <= 1'b0;
      pend2_q <= 1'b0;  nullify_q <= 1'b0;  lwr_q <= 1'b0;  ldst_q <= '0;
      prog_rd_q <= 1'b0;  prog_tbl_q <= 1'b0;  exec_valid_q <= 1'b0;  exec_word_q <= '0;
      exec_nop_q <= 1'b0;  exec_opnd_q <= 1'b0;  exec_rw2_q <= 1'b0;  stall_q <= 1'b0;
      addr_trap_q <= 1'b0;  wreg_we_q <= 1'b0;  wreg_wsel_q <= '0;  wreg_wdata_q <= '0;
      alu_shift_q <= 1'b0;
    end else begin
      state_q <= state_d;  pc_q <= pc_d;  prog_addr_q <= prog_addr_d;
      hold_q <= hold_d;  hold_v_q <= hold_v_d;  fetched_q <= fetched_d;  discard_q <= discard_d;
      pend2_q <= pend2_d;  nullify_q <= nullify_d;  lwr_q <= lwr_d;  ldst_q <= ldst_d;
      prog_rd_q <= prog_rd_d;  prog_tbl_q <= prog_tbl_d;  exec_valid_q <= exec_valid_d;
      exec_word_q <= exec_word_d;  exec_nop_q <= exec_nop_d;  exec_opnd_q <= exec_opnd_d;
      exec_rw2_q <= exec_rw2_d;  stall_q <= stall_d;  addr_trap_q <= addr_trap_d;
      wreg_we_q <= wreg_we_d;  wreg_wsel_q <= wreg_wsel_d;  wreg_wdata_q <= wreg_wdata_d;
      alu_shift_q <= alu_shift_d;
    end
  end

  // outputs straight from flops
  assign prog_addr  = prog_addr_q;
  assign prog_rd    = prog_rd_q;
  assign prog_tbl   = prog_tbl_q;
  assign exec_valid = exec_valid_q;
  assign exec_word  = exec_word_q;
  assign exec_nop   = exec_nop_q;
  assign exec_opnd  = exec_opnd_q;
  assign exec_rw2   = exec_rw2_q;
  assign stall      = stall_q;
  assign addr_trap  = addr_trap_q;
  assign wreg_we    = wreg_we_q;
  assign wreg_wsel  = wreg_wsel_q;
  assign wreg_wdata = wreg_wdata_q;
  assign alu_shift  = alu_shift_q;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_q);
  logic run_x;
  assign run_x = exec_valid_q & ~exec_nop_q & ~exec_opnd_q & ~exec_rw2_q;

  property p_shift_res;
    wreg_we_q && !alu_shift_q |-> wreg_wdata_q == (
      (op_of(exec_word_q) == shift_left_op) ? ($past(shift_src) << exec_word_q[AMT_HI:AMT_LO]) :
      (op_of(exec_word_q) == arith_shift_right) ?
        DATA_W'($signed($past(shift_src)) >>> exec_word_q[AMT_HI:AMT_LO]) :
      ($past(shift_src) >> exec_word_q[AMT_HI:AMT_LO]));
  endproperty
  a_shift_res: assert property (p_shift_res) else $error("barrel result wrong");
  property p_alu_one;
    alu_shift_q |-> wreg_we_q && exec_word_q[AMT_HI:AMT_LO] == AMT_ONE;
  endproperty
  a_alu_one: assert property (p_alu_one) else $error("alu shift on wrong amount");
  property p_dwm;
    run_x && cls_of(exec_word_q) == CLS_DWM |=> exec_valid_q && exec_rw2_q && !prog_rd_q;
  endproperty
  a_dwm: assert property (p_dwm) else $error("double move not two cycles");
  property p_branch;
    run_x && cls_of(exec_word_q) == CLS_BRANCH |=> !exec_valid_q && prog_rd_q ##1 exec_valid_q;
  endproperty
  a_branch: assert property (p_branch) else $error("branch flush wrong");
  property p_ret;
    run_x && cls_of(exec_word_q) == CLS_RET |=> !exec_valid_q [*2] ##1 exec_valid_q;
  endproperty
  a_ret: assert property (p_ret) else $error("return not three cycles");
  property p_skip2;
    exec_nop_q && cls_of(exec_word_q) == CLS_TWO_LO |=> exec_valid_q && exec_nop_q;
  endproperty
  a_skip2: assert property (p_skip2) else $error("skipped second word not nop");
  property p_two;
    run_x && cls_of(exec_word_q) == CLS_TWO_LO |=> exec_valid_q && exec_opnd_q;
  endproperty
  a_two: assert property (p_two) else $error("two-word not two cycles");
  property p_orphan;
    exec_valid_q && !exec_opnd_q && cls_of(exec_word_q) == CLS_TWO_HI |-> exec_nop_q;
  endproperty
  a_orphan: assert property (p_orphan) else $error("orphan word executed");
  property p_stall;
    stall_q |-> !exec_valid_q ##1 (exec_valid_q && !stall_q);
  endproperty
  a_stall: assert property (p_stall) else $error("stall not one cycle");
  property p_tbl;
    prog_tbl_q |-> prog_rd_q && !exec_valid_q ##1 exec_valid_q;
  endproperty
  a_tbl: assert property (p_tbl) else $error("table op sequencing wrong");
  c_branch: cover property (run_x && cls_of(exec_word_q) == CLS_BRANCH);
  c_ret:    cover property (run_x && cls_of(exec_word_q) == CLS_RET);
  c_stall:  cover property (stall_q);
  c_skip2:  cover property (exec_nop_q ##1 exec_nop_q);
endmodule

/* verilog/cfs_pkg.sv */
// constants and types shared by the fetch sequencer and shifter
package cfs_pkg;
  localparam int PC_W   = 24;
  localparam int WORD_W = 24;
  localparam int DATA_W = 16;
  localparam int REG_W  = 4;
  localparam int AMT_W  = 4;
  // pc behaviour
  localparam logic [PC_W-1:0] PC_RESET = 24'h000000;
  localparam logic [PC_W-1:0] PC_STEP  = 24'h000002;
  localparam logic [PC_W-1:0] PM_LIMIT = 24'h00fffe; // last implemented word address
  // instruction word field positions
  localparam int CLS_HI   = 23;
  localparam int CLS_LO   = 20;
  localparam int DWR_BIT  = 19;
  localparam int DST_HI   = 18;
  localparam int DST_LO   = 15;
  localparam int SIND_BIT = 14;
  localparam int SRC_HI   = 13;
  localparam int SRC_LO   = 10;
  localparam int SOP_HI   = 9;
  localparam int SOP_LO   = 8;
  localparam int AMT_HI   = 7;
  localparam int AMT_LO   = 4;
  localparam logic [AMT_W-1:0] AMT_ONE = 4'h1;
  // instruction flow classes
  typedef enum logic [3:0] {
    CLS_ONE    = 4'h0,
    CLS_SHIFT  = 4'h1,
    CLS_DWM    = 4'h2,
    CLS_BRANCH = 4'h3,
    CLS_SKIP   = 4'h4,
    CLS_RET    = 4'h5,
    CLS_TBL    = 4'h6,
    CLS_TWO_LO = 4'h7,
    CLS_TWO_HI = 4'h8
  } cfs_class_type;
  // shift operations
  typedef enum logic [1:0] {
    arith_shift_right = 2'h0,
    logic_shift_right = 2'h1,
    shift_left_op     = 2'h2
  } cfs_shop_type;
  // sequencer states
  typedef enum logic [2:0] {ST_RUN, ST_DWM2, ST_TBL, ST_RET2, ST_RET3} cfs_state_type;
endpackage

/* testbench/cfs_pmem.sv */
// program memory model answering each registered fetch address in its own cycle
`timescale 1ns/10ps
module cfs_pmem (
  // clock
  input  wire logic                       sys_clk,
  // fetch request
  input  wire logic [cfs_pkg::PC_W-1:0]   prog_addr,
  input  wire logic                       prog_rd,
  // read data
  output logic [cfs_pkg::WORD_W-1:0]      pm_rdata
);
  logic [cfs_pkg::WORD_W-1:0] mem [0:63];
  logic [cfs_pkg::WORD_W-1:0] idle_q = 24'h000000;

  // the core registers the address, so the word must stand while prog_rd stands
  // and be taken at the edge that closes that cycle; outside a read the lines
  // toggle every cycle, so a design that samples late never sees a stale word
  always @(posedge sys_clk) begin
    idle_q <= ~idle_q;
  end
  assign pm_rdata = prog_rd ? mem[prog_addr[6:1]] : idle_q;
endmodule

/* testbench/cfs_core_tb.sv */
// self-checking testbench for the fetch sequencer and shifter
`timescale 1ns/10ps
module cfs_core_tb;
  import cfs_pkg::*;
  typedef struct packed {
    logic v, nop, opnd, rw2, stl, trp, we, als, pr, pt;
    logic [REG_W-1:0]  ws;
    logic [DATA_W-1:0] wd;
    logic [WORD_W-1:0] w;
    logic [PC_W-1:0]   pa;
  } cfs_ev_type;
  logic              sys_clk     = 1'b0;
  logic              rst_b       = 1'b0;
  logic              skip_cond   = 1'b0;
  logic [PC_W-1:0]   flow_target = 24'h000000;
  logic [PC_W-1:0]   ret_addr    = 24'h000000;
  logic [PC_W-1:0]   tbl_addr    = 24'h000000;
  logic [DATA_W-1:0] shift_src   = 16'h0000;
  logic [PC_W-1:0]   prog_addr;
  logic [WORD_W-1:0] pm_rdata, exec_word;
  logic              prog_rd, prog_tbl, exec_valid, exec_nop, exec_opnd, exec_rw2;
  logic              stall, addr_trap, wreg_we, alu_shift;
  logic [REG_W-1:0]  wreg_wsel;
  logic [DATA_W-1:0] wreg_wdata;
  cfs_ev_type        ev [0:63];
  int                fail_count   = 0;
  int                total_checks = 0;
  int                cyc          = 0;

  always #2.5 sys_clk = ~sys_clk;

  cfs_core i_cfs_core (.sys_clk(sys_clk), .rst_b(rst_b), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .prog_tbl(prog_tbl), .pm_rdata(pm_rdata), .skip_cond(skip_cond),
    .flow_target(flow_target), .ret_addr(ret_addr), .tbl_addr(tbl_addr),
    .shift_src(shift_src), .exec_valid(exec_valid), .exec_word(exec_word),
    .exec_nop(exec_nop), .exec_opnd(exec_opnd), .exec_rw2(exec_rw2), .stall(stall),
    .addr_trap(addr_trap), .wreg_we(wreg_we), .wreg_wsel(wreg_wsel),
    .wreg_wdata(wreg_wdata), .alu_shift(alu_shift));

  cfs_pmem i_cfs_pmem (.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .pm_rdata(pm_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  // a hang is cut short here; nine short runs need well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  function automatic logic [23:0] mk(input logic [3:0] c, input logic dw,
      input logic [3:0] d, input logic si, input logic [3:0] s, input logic [1:0] op,
      input logic [3:0] am);
    mk = {c, dw, d, si, s, op, am, 4'h0};
  endfunction

  // fill with one-cycle words whose low bits name their own slot
  task automatic ld();
    for (int i = 0; i < 64; i++) i_cfs_pmem.mem[i] = 24'(i);
  endtask

  // reset, then log every cycle; b is the cycle in which word 0 executes
  task automatic run(input logic sk, input logic [23:0] ft, input logic [23:0] ra,
      input logic [23:0] ta, input logic [15:0] ss, output int b);
    @(posedge sys_clk);
    rst_b       <= 1'b0;
    skip_cond   <= sk;
    flow_target <= ft;
    ret_addr    <= ra;
    tbl_addr    <= ta;
    shift_src   <= ss;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 64; k++) begin
      @(negedge sys_clk);
      ev[k] = {exec_valid, exec_nop, exec_opnd, exec_rw2, stall, addr_trap, wreg_we,
               alu_shift, prog_rd, prog_tbl, wreg_wsel, wreg_wdata, exec_word, prog_addr};
    end
    b = -1;
    for (int k = 20; k >= 0; k--) if (ev[k].v === 1'b1) b = k;
    chk("first execution seen", 32'(b >= 0), 32'h1);
    if (b < 0) b = 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_shift();
    int b, k;
    logic [15:0] e;
    ld();
    for (int op = 0; op < 3; op++)
      for (int a = 1; a < 16; a++)
        i_cfs_pmem.mem[op*15+a-1] = mk(CLS_SHIFT, 1'b1, 4'(a), 1'b0, 4'h0, 2'(op), 4'(a));
    run(1'b0, 24'h0, 24'h0, 24'h0, 16'h9a35, b);
    for (int op = 0; op < 3; op++)
      for (int a = 1; a < 16; a++) begin
        k = b + op*15 + a - 1;
        case (op)
          0: e = 16'($signed(16'h9a35) >>> a);
          1: e = 16'h9a35 >> a;
          default: e = 16'h9a35 << a;
        endcase
        chk("shift result", 32'(ev[k].wd), 32'(e));
        chk("shift dest", 32'(ev[k].ws), 32'(a));
        chk("alu path", 32'(ev[k].als), 32'(a == 1));
        chk("exec and write", 32'({ev[k].v, ev[k].we}), 32'h3);
      end
    $display("shift test done");
  endtask

  task automatic t_dwm();
    int b;
    ld();
    i_cfs_pmem.mem[1] = mk(CLS_DWM, 1'b0, 4'h0, 1'b0, 4'h1, 2'h0, 4'h0);
    run(1'b0, 24'h0, 24'h0, 24'h0, 16'h0, b);
    chk("second rw cycle", 32'(ev[b+2].rw2), 32'h1);
    chk("held word", 32'({ev[b+3].v, ev[b+3].rw2, ev[b+3].w}), 32'h2000002);
    $display("double word move test done");
  endtask

  task automatic t_branch();
    int b;
    ld();
    i_cfs_pmem.mem[1] = mk(CLS_BRANCH, 1'b0, 4'h0, 1'b0, 4'h0, 2'h0, 4'h0);
    run(1'b0, 24'h000020, 24'h0, 24'h0, 16'h0, b);
    chk("redirect fetch", 32'({ev[b+2].pr, ev[b+2].pa}), 32'h1000020);
    chk("discarded slot", 32'({ev[b+2].v, ev[b+2].nop}), 32'h0);
    chk("target exec", 32'({ev[b+3].v, ev[b+3].w}), 32'h1000010);
    $display("branch test done");
  endtask

  task automatic t_skip();
    int b;
    ld();
    i_cfs_pmem.mem[0] = mk(CLS_SKIP, 1'b0, 4'h0, 1'b0, 4'h0, 2'h0, 4'h0);
    i_cfs_pmem.mem[1] = mk(CLS_TWO_LO, 1'b0, 4'h0, 1'b0, 4'h0, 2'h0, 4'h1);
    i_cfs_pmem.mem[2] = mk(CLS_TWO_HI, 1'b0, 4'h0, 1'b0, 4'h0, 2'h0, 4'h2);
    run(1'b1, 24'h0, 24'h0, 24'h0, 16'h0, b);
    chk("skip nops", 32'({ev[b+1].nop, ev[b+2].nop, ev[b+3].nop}), 32'h6);
    chk("after skip", 32'({ev[b+3].v, ev[b+3].w}), 32'h1000003);
    $display("skip test done");
  endtask

  task automatic t_two();
    int b;
    ld();
    i_cfs_pmem.mem[0] = mk(CLS_TWO_LO, 1'b0, 4'h0, 1'b0, 4'h0, 2'h0, 4'h1);
    i_cfs_pmem.mem[1] = mk(CLS_TWO_HI, 1'b0, 4'h0, 1'b0, 4'h0, 2'h0, 4'h5);
    i_cfs_pmem.mem[2] = mk(CLS_TWO_HI, 1'b0, 4'h0, 1'b0, 4'h0, 2'h0, 4'h6);
    run(1'b0, 24'h0, 24'h0, 24'h0, 16'h0, b);
    chk("operand word", 32'({ev[b+1].opnd, ev[b+1].nop, ev[b+1].w}),
        32'({2'b10, i_cfs_pmem.mem[1]}));
    chk("orphan nop", 32'({ev[b+2].nop, ev[b+2].opnd}), 32'h2);
    chk("after pair", 32'({ev[b+3].v, ev[b+3].w}), 32'h1000003);
    $display("two word test done");
  endtask

  task automatic t_ret();
    int b;
    ld();
    i_cfs_pmem.mem[1] = mk(CLS_RET, 1'b0, 4'h0, 1'b0, 4'h0, 2'h0, 4'h0);
    // last legal landing spot: both refill words exist
    run(1'b0, 24'h0, PM_LIMIT - PC_STEP, 24'h0, 16'h0, b);
    chk("return gap", 32'({ev[b+2].v, ev[b+3].v}), 32'h0);
    chk("return target", 32'({ev[b+4].v, ev[b+4].w}), 32'h100003e);
    chk("no trap", 32'({ev[b+2].trp, ev[b+3].trp, ev[b+4].trp}), 32'h0);
    run(1'b0, 24'h0, PM_LIMIT, 24'h0, 16'h0, b);
    chk("refill trap", 32'({ev[b+2].trp, ev[b+3].trp}), 32'h1);
    $display("return test done");
  endtask

  task automatic t_tbl();
    int b;
    ld();
    i_cfs_pmem.mem[1] = mk(CLS_TBL, 1'b0, 4'h0, 1'b0, 4'h0, 2'h0, 4'h0);
    run(1'b0, 24'h0, 24'h0, 24'h000040, 16'h0, b);
    chk("table cycle", 32'({ev[b+2].v, ev[b+2].pr, ev[b+2].pt, ev[b+2].pa}),
        32'h3000040);
    chk("held word", 32'({ev[b+3].v, ev[b+3].w}), 32'h1000002);
    chk("fetch resumes", 32'({ev[b+4].v, ev[b+4].w}), 32'h1000003);
    $display("table test done");
  endtask

  task automatic t_stall();
    int b;
    ld();
    i_cfs_pmem.mem[0] = mk(CLS_ONE, 1'b1, 4'h3, 1'b0, 4'h0, 2'h0, 4'h0);
    i_cfs_pmem.mem[1] = mk(CLS_ONE, 1'b0, 4'h0, 1'b1, 4'h3, 2'h0, 4'h0);
    i_cfs_pmem.mem[2] = mk(CLS_ONE, 1'b1, 4'h6, 1'b1, 4'h5, 2'h0, 4'h0);
    i_cfs_pmem.mem[3] = mk(CLS_ONE, 1'b0, 4'h0, 1'b1, 4'h7, 2'h0, 4'h0);
    run(1'b0, 24'h0, 24'h0, 24'h0, 16'h0, b);
    chk("stall slots", 32'({ev[b+1].stl, ev[b+2].stl, ev[b+3].stl, ev[b+4].stl}),
        32'h8);
    chk("stalled word", 32'({ev[b+2].v, ev[b+2].w}),
        32'({1'b1, i_cfs_pmem.mem[1]}));
    chk("unrelated word", 32'({ev[b+4].v, ev[b+4].w}),
        32'({1'b1, i_cfs_pmem.mem[3]}));
    $display("stall test done");
  endtask

  initial begin
    t_shift();
    t_dwm();
    t_branch();
    t_skip();
    t_two();
    t_ret();
    t_tbl();
    t_stall();
    stop_test();
  end
endmodule
